//--- bench/crsf_dp_model.sv
// Datapath and interrupt acknowledge side of the register set
`timescale 1ns/1ps
module crsf_dp_model (
	// Clock
	input  wire logic           clk,
	// Datapath side
	output logic                dp_wr_en,
	output crsf_pkg::crsf_sel_t dp_wr_sel,
	output logic [31:0]         dp_wr_data,
	output logic                instr_done,
	output logic                int_ack
);
	import crsf_pkg::*;
	// Idle levels
	initial begin
		dp_wr_en = 1'b0;
		dp_wr_sel = SEL_DATA_REG_0;
		dp_wr_data = 32'h0;
		instr_done = 1'b0;
		int_ack = 1'b0;
	end
	// One-cycle write strobe, data scrambled after
	task automatic wr(input crsf_sel_t s, input logic [31:0] d);
		@(posedge clk);
		dp_wr_en <= 1'b1;
		dp_wr_sel <= s;
		dp_wr_data <= d;
		@(posedge clk);
		dp_wr_en <= 1'b0;
		dp_wr_data <= ~d;
	endtask : wr
	// Boundary and acknowledge pulses
	task automatic ev(input logic d, input logic a);
		@(posedge clk);
		instr_done <= d;
		int_ack <= a;
		@(posedge clk);
		instr_done <= 1'b0;
		int_ack <= 1'b0;
	endtask : ev
endmodule : crsf_dp_model

//--- bench/crsf_regs_tb_top.sv
// Self-checking bench for the register set
`timescale 1ns/1ps
module crsf_regs_tb_top;
	import crsf_pkg::*;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, dp_wr_en;
	logic        instr_done, int_ack, int_req, int_req_maskable, int_accept, active_bank;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, dp_rd_data, dp_wr_data, rd, pw;
	logic [2:0]  int_req_prio;
	logic [15:0] addr_reg_0, frame_base, active_stack;
	logic [3:0]  alu_we, alu_val, v;
	logic        swi_exec, int_ack_single_step, single_step_req;
	logic [5:0]  swi_vector;
	crsf_sel_t   dp_wr_sel, dp_rd_sel;
	int unsigned bm [2][7];
	int unsigned us, is_;
	int          miscompares = 0;
	int          n_checks = 0;
	crsf_dp_model dp (.clk(clk), .dp_wr_en(dp_wr_en), .dp_wr_sel(dp_wr_sel),
		.dp_wr_data(dp_wr_data), .instr_done(instr_done), .int_ack(int_ack));
	crsf_regs dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dp_wr_en(dp_wr_en), .dp_wr_sel(dp_wr_sel), .dp_wr_data(dp_wr_data),
		.dp_rd_sel(dp_rd_sel), .dp_rd_data(dp_rd_data), .alu_we(alu_we), .alu_val(alu_val),
		.instr_done(instr_done), .int_req(int_req), .int_req_maskable(int_req_maskable),
		.int_req_prio(int_req_prio), .int_ack(int_ack),
		.int_ack_single_step(int_ack_single_step), .swi_exec(swi_exec),
		.swi_vector(swi_vector), .int_accept(int_accept), .single_step_req(single_step_req),
		.addr_reg_0(addr_reg_0), .addr_reg_1(), .frame_base(frame_base), .static_base(),
		.active_stack(active_stack), .program_counter(), .vector_table_base(),
		.processor_flag_word(), .active_bank(active_bank));
	// Clock
	always #10 clk = ~clk;
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			$display("FAIL %s expected %h seen %h", nm, x, g);
			miscompares++;
		end
	endtask : chk
	// APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Datapath read, sampled one cycle after the selector is taken
	task automatic dprd(input crsf_sel_t s);
		@(posedge clk);
		dp_rd_sel <= s;
		@(posedge clk);
		#1;
	endtask : dprd
	// Software interrupt pulse with its vector number
	task automatic swi(input logic [5:0] s);
		@(posedge clk);
		swi_exec <= 1'b1;
		swi_vector <= s;
		@(posedge clk);
		swi_exec <= 1'b0;
	endtask : swi
	// Watchdog
	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		dp_rd_sel = SEL_DATA_REG_0;
		int_req = 1'b0;
		int_req_maskable = 1'b1;
		int_req_prio = 3'h0;
		alu_we = 4'h0;
		alu_val = 4'h0;
		swi_exec = 1'b0;
		swi_vector = 6'h00;
		int_ack_single_step = 1'b0;
		rd = $urandom(32'h87d6);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFS_FLG, 32'h0);
		chk("flag_rst", 32'h0, rd);
		apb(1'b1, OFS_FLG, 32'hffff);
		apb(1'b0, OFS_FLG, 32'h0);
		chk("flag_mask", 32'h70ff, rd);
		apb(1'b1, OFS_FLG, 32'h0);
		$display("test flags done");
		foreach (bm[b, i]) begin
			bm[b][i] = $urandom & 32'hffff;
			apb(1'b1, 8'(b * 32 + i * 4), bm[b][i]);
		end
		foreach (bm[b, i]) begin
			apb(1'b0, 8'(b * 32 + i * 4), 32'h0);
			chk("bank_rd", bm[b][i], rd);
		end
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		$display("test banks done");
		apb(1'b1, OFS_FLG, 32'h10);
		chk("bank_hold", 32'h0, {31'h0, active_bank});
		dp.ev(1'b1, 1'b0);
		#1;
		chk("bank_sel", 32'h1, {31'h0, active_bank});
		chk("addr_base", bm[1][4], {16'h0, addr_reg_0});
		chk("frame_base", bm[1][6], {16'h0, frame_base});
		dprd(SEL_DATA_PAIR_HIGH);
		chk("pair_high", (bm[1][3] << 16) | bm[1][1], dp_rd_data);
		dprd(SEL_ADDR_PAIR);
		chk("addr_pair", (bm[1][5] << 16) | bm[1][4], dp_rd_data);
		dprd(SEL_DATA_REG_0_HIGH);
		chk("byte_high", bm[1][0] >> 8, dp_rd_data);
		pw = $urandom;
		dp.wr(SEL_DATA_PAIR_LOW, pw);
		apb(1'b0, 8'h28, 32'h0);
		chk("pair_wr", {16'h0, pw[31:16]}, rd);
		$display("test bank select done");
		us = $urandom & 32'hffff;
		is_ = $urandom & 32'hffff;
		apb(1'b1, OFS_USTK, us);
		apb(1'b1, OFS_ISTK, is_);
		apb(1'b1, OFS_FLG, 32'h30d0);
		dp.ev(1'b1, 1'b0);
		#1;
		chk("stack_user", us, {16'h0, active_stack});
		for (int p = 0; p < 8; p++) begin
			@(posedge clk);
			int_req <= 1'b1;
			int_req_prio <= 3'(p);
			#1;
			chk("accept", {31'h0, p > 3}, {31'h0, int_accept});
		end
		dp.ev(1'b0, 1'b1);
		#1;
		chk("stack_isp", is_, {16'h0, active_stack});
		apb(1'b0, OFS_FLG, 32'h0);
		chk("flag_ack", 32'h3010, rd);
		chk("masked", 32'h0, {31'h0, int_accept});
		$display("test interrupts done");
		apb(1'b1, OFS_FLG, 32'h2);
		dp.ev(1'b1, 1'b0);
		#1;
		chk("step_req", 32'h1, {31'h0, single_step_req});
		v = 4'($urandom);
		@(posedge clk);
		alu_we <= 4'hf;
		alu_val <= v;
		int_ack_single_step <= 1'b1;
		@(posedge clk);
		alu_we <= 4'h0;
		int_ack_single_step <= 1'b0;
		apb(1'b0, OFS_FLG, 32'h0);
		chk("alu_flags", {26'h0, v[3], 1'b0, v[2], v[1], 1'b0, v[0]}, rd);
		apb(1'b1, OFS_FLG, 32'h80);
		dp.ev(1'b1, 1'b0);
		swi(6'(32 + $urandom % 32));
		apb(1'b0, OFS_FLG, 32'h0);
		chk("swi_high", 32'h80, rd);
		swi(6'($urandom % 32));
		apb(1'b0, OFS_FLG, 32'h0);
		chk("swi_low", 32'h0, rd);
		chk("swi_stack", is_, {16'h0, active_stack});
		$display("test flag updates done");
		wrap_up();
	end
endmodule : crsf_regs_tb_top

//--- src/crsf_bank.sv
// Two banks of seven 16-bit registers with two write lanes
`timescale 1ns/1ps
module crsf_bank (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Store port
	crsf_bank_if.bank p
);
	import crsf_pkg::*;

	logic [15:0] mem [NBANK][NBANKED];

	// Two lanes, low lane has byte enables
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int b = 0; b < NBANK; b++) begin
				for (int i = 0; i < NBANKED; i++) begin
					mem[b][i] <= REG_RST;
				end
			end
		end else begin
			if (p.we_lo && p.be_lo[0]) begin
				mem[p.wbank][p.idx_lo][7:0] <= p.wd_lo[7:0];
			end
			if (p.we_lo && p.be_lo[1]) begin
				mem[p.wbank][p.idx_lo][15:8] <= p.wd_lo[15:8];
			end
			if (p.we_hi) begin
				mem[p.wbank][p.idx_hi] <= p.wd_hi;
			end
		end
	end

	// Active bank taps and a software read tap
	always_comb begin
		for (int i = 0; i < NBANKED; i++) begin
			p.act[i] = mem[p.rbank][i];
		end
		p.ard = mem[p.abank][p.aidx];
	end

	a_bank_word_write: assert property (@(posedge clk) disable iff (rst)
		p.we_lo && p.be_lo == 2'h3 && !(p.we_hi && p.idx_hi == p.idx_lo)
		|=> mem[$past(p.wbank)][$past(p.idx_lo)] == $past(p.wd_lo))
		else $error("banked word write lost");
endmodule : crsf_bank

//--- src/crsf_bank_if.sv
// Write lanes and read taps between the register set and its banked store
`timescale 1ns/1ps
interface crsf_bank_if;
	import crsf_pkg::*;
	logic              we_lo;
	logic [2:0]        idx_lo;
	logic [1:0]        be_lo;
	logic [15:0]       wd_lo;
	logic              we_hi;
	logic [2:0]        idx_hi;
	logic [15:0]       wd_hi;
	logic              wbank;
	logic              rbank;
	logic [15:0]       act [NBANKED];
	logic              abank;
	logic [2:0]        aidx;
	logic [15:0]       ard;

	modport bank (input we_lo, idx_lo, be_lo, wd_lo, we_hi, idx_hi, wd_hi, wbank,
		rbank, abank, aidx, output act, ard);
	modport user (output we_lo, idx_lo, be_lo, wd_lo, we_hi, idx_hi, wd_hi, wbank,
		rbank, abank, aidx, input act, ard);
endinterface : crsf_bank_if

//--- src/crsf_gate.sv
// Interrupt acceptance against enable flag and priority level
`timescale 1ns/1ps
module crsf_gate (
	// Request
	input  wire logic       req,
	input  wire logic       req_maskable,
	input  wire logic [2:0] req_prio,
	// Flag state
	input  wire logic       int_enable,
	input  wire logic [2:0] prio_level,
	// Decision
	output logic            accept
);
	import crsf_pkg::*;

	// Strictly higher priority, maskable ones also need the enable flag
	assign accept = req && (req_prio > prio_level)
		&& (!req_maskable || int_enable);

	a_gate_prio: assert property (@(posedge req) accept |-> req_prio > prio_level)
		else $error("accepted at or below level");
endmodule : crsf_gate

//--- src/crsf_pkg.sv
// Constants and types shared by the register set and its helpers
package crsf_pkg;

	// ------------------------------------------------------------------
	// Widths and bank layout
	// ------------------------------------------------------------------
	localparam int         DW        = 16;
	localparam int         PCW       = 20;
	localparam int         NBANK     = 2;
	localparam int         NBANKED   = 7;
	localparam logic [2:0] BK_DATA0  = 3'h0;
	localparam logic [2:0] BK_DATA1  = 3'h1;
	localparam logic [2:0] BK_DATA2  = 3'h2;
	localparam logic [2:0] BK_DATA3  = 3'h3;
	localparam logic [2:0] BK_ADDR0  = 3'h4;
	localparam logic [2:0] BK_ADDR1  = 3'h5;
	localparam logic [2:0] BK_FRAME  = 3'h6;

	// ------------------------------------------------------------------
	// Flag word fields
	// ------------------------------------------------------------------
	localparam int          FL_C       = 0;
	localparam int          FL_D       = 1;
	localparam int          FL_Z       = 2;
	localparam int          FL_S       = 3;
	localparam int          FL_B       = 4;
	localparam int          FL_O       = 5;
	localparam int          FL_I       = 6;
	localparam int          FL_U       = 7;
	localparam int          FL_IPL_LO  = 12;
	localparam int          FL_IPL_HI  = 14;
	localparam logic [15:0] FLG_MASK   = 16'h70ff;
	localparam logic [15:0] FLG_RST    = 16'h0000;
	localparam logic [15:0] REG_RST    = 16'h0000;
	localparam logic [19:0] WIDE_RST   = 20'h00000;
	localparam logic [5:0]  SWI_U_MAX  = 6'h1f;

	// ------------------------------------------------------------------
	// APB byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_BANK0  = 8'h00;
	localparam logic [7:0] OFS_BANK1  = 8'h20;
	localparam logic [7:0] OFS_PC     = 8'h40;
	localparam logic [7:0] OFS_VTB    = 8'h44;
	localparam logic [7:0] OFS_USTK   = 8'h48;
	localparam logic [7:0] OFS_ISTK   = 8'h4c;
	localparam logic [7:0] OFS_STATB  = 8'h50;
	localparam logic [7:0] OFS_FLG    = 8'h54;
	localparam logic [7:0] OFS_STAT   = 8'h58;

	// ------------------------------------------------------------------
	// Datapath register selectors
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		SEL_DATA_REG_0      = 5'h00,
		SEL_DATA_REG_1      = 5'h01,
		SEL_DATA_REG_2      = 5'h02,
		SEL_DATA_REG_3      = 5'h03,
		SEL_ADDR_REG_0      = 5'h04,
		SEL_ADDR_REG_1      = 5'h05,
		SEL_FRAME_BASE      = 5'h06,
		SEL_DATA_REG_0_LOW  = 5'h08,
		SEL_DATA_REG_0_HIGH = 5'h09,
		SEL_DATA_REG_1_LOW  = 5'h0a,
		SEL_DATA_REG_1_HIGH = 5'h0b,
		SEL_DATA_PAIR_LOW   = 5'h0c,
		SEL_DATA_PAIR_HIGH  = 5'h0d,
		SEL_ADDR_PAIR       = 5'h0e,
		SEL_PROGRAM_COUNTER = 5'h10,
		SEL_VECTOR_TABLE    = 5'h11,
		SEL_USER_STACK      = 5'h12,
		SEL_INTR_STACK      = 5'h13,
		SEL_ACTIVE_STACK    = 5'h14,
		SEL_STATIC_BASE     = 5'h15,
		SEL_FLAG_WORD       = 5'h16
	} crsf_sel_t;

endpackage : crsf_pkg

//--- src/crsf_regs.sv
// Architectural register set and flag word with APB access
`timescale 1ns/1ps
module crsf_regs (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Datapath write and read ports
	input  wire logic               dp_wr_en,
	input  wire crsf_pkg::crsf_sel_t dp_wr_sel,
	input  wire logic [31:0]        dp_wr_data,
	input  wire crsf_pkg::crsf_sel_t dp_rd_sel,
	output logic [31:0]             dp_rd_data,
	// Arithmetic flag updates, order C Z S O
	input  wire logic [3:0]         alu_we,
	input  wire logic [3:0]         alu_val,
	// Instruction and interrupt events
	input  wire logic               instr_done,
	input  wire logic               int_req,
	input  wire logic               int_req_maskable,
	input  wire logic [2:0]         int_req_prio,
	input  wire logic               int_ack,
	input  wire logic               int_ack_single_step,
	input  wire logic               swi_exec,
	input  wire logic [5:0]         swi_vector,
	output logic                    int_accept,
	output logic                    single_step_req,
	// Address generation bases and state taps
	output logic [15:0]             addr_reg_0,
	output logic [15:0]             addr_reg_1,
	output logic [15:0]             frame_base,
	output logic [15:0]             static_base,
	output logic [15:0]             active_stack,
	output logic [19:0]             program_counter,
	output logic [19:0]             vector_table_base,
	output logic [15:0]             processor_flag_word,
	output logic                    active_bank
);
	import crsf_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [19:0] pc_r, vtb_r;
	logic [15:0] ustk_r, istk_r, statb_r, flg_r, flg_nxt;
	logic        bank_eff_r, u_eff_r, ss_req_r;
	logic [31:0] rd_r, prdata_r;
	logic        hw_busy, apb_wr, apb_err, apb_bank_hit;
	crsf_bank_if bif ();

	// Keep reserved flag positions at zero
	function automatic logic [15:0] flg_clean(input logic [31:0] v);
		return v[15:0] & FLG_MASK;
	endfunction : flg_clean

	function automatic logic sel_is(input crsf_sel_t s, input crsf_sel_t t, input logic en);
		return en && s == t;
	endfunction : sel_is

	crsf_bank u_bank (
		.clk (clk),
		.rst (rst),
		.p   (bif.bank)
	);

	crsf_gate u_gate (
		.req          (int_req),
		.req_maskable (int_req_maskable),
		.req_prio     (int_req_prio),
		.int_enable   (flg_r[FL_I]),
		.prio_level   (flg_r[FL_IPL_HI:FL_IPL_LO]),
		.accept       (int_accept)
	);

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// Writes wait during datapath writes, arithmetic flag updates, int_ack or swi_exec, but not int_ack_single_step
	assign hw_busy = dp_wr_en || (alu_we != 4'h0) || int_ack || swi_exec;
	assign apb_wr  = psel && penable && pwrite && !hw_busy;
	assign pready  = !(pwrite && hw_busy);
	assign prdata  = prdata_r;
	assign apb_bank_hit = (paddr < OFS_PC) && (paddr[4:2] != 3'h7) && (paddr[1:0] == 2'h0);

	// Unmapped or misaligned addresses report an error
	always_comb begin
		if (apb_bank_hit) begin
			apb_err = 1'b0;
		end else if (paddr >= OFS_PC && paddr <= OFS_STAT && paddr[1:0] == 2'h0) begin
			apb_err = pwrite && paddr == OFS_STAT;
		end else begin
			apb_err = 1'b1;
		end
	end
	assign pslverr = psel && penable && apb_err;

	// Read data captured in the setup phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_r <= 32'h00000000;
		end else if (psel && !penable) begin
			if (apb_bank_hit) begin
				prdata_r <= {16'h0000, bif.ard};
			end else if (paddr == OFS_PC) begin
				prdata_r <= {12'h000, pc_r};
			end else if (paddr == OFS_VTB) begin
				prdata_r <= {12'h000, vtb_r};
			end else if (paddr == OFS_USTK) begin
				prdata_r <= {16'h0000, ustk_r};
			end else if (paddr == OFS_ISTK) begin
				prdata_r <= {16'h0000, istk_r};
			end else if (paddr == OFS_STATB) begin
				prdata_r <= {16'h0000, statb_r};
			end else if (paddr == OFS_FLG) begin
				prdata_r <= {16'h0000, flg_r};
			end else if (paddr == OFS_STAT) begin
				prdata_r <= {28'h0000000, ss_req_r, int_accept, u_eff_r, bank_eff_r};
			end else begin
				prdata_r <= 32'h00000000;
			end
		end
	end

	// ------------------------------------------------------------------
	// Banked store lanes
	// ------------------------------------------------------------------
	assign bif.rbank = bank_eff_r;
	assign bif.abank = paddr[5];
	assign bif.aidx  = paddr[4:2];

	// Datapath writes own the lanes, software fills idle cycles
	always_comb begin
		bif.we_lo  = 1'b0;
		bif.idx_lo = BK_DATA0;
		bif.be_lo  = 2'h3;
		bif.wd_lo  = dp_wr_data[15:0];
		bif.we_hi  = 1'b0;
		bif.idx_hi = BK_DATA2;
		bif.wd_hi  = dp_wr_data[31:16];
		bif.wbank  = bank_eff_r;
		if (dp_wr_en) begin
			case (dp_wr_sel)
				SEL_DATA_REG_0, SEL_DATA_REG_1, SEL_DATA_REG_2, SEL_DATA_REG_3,
				SEL_ADDR_REG_0, SEL_ADDR_REG_1, SEL_FRAME_BASE: begin
					bif.we_lo  = 1'b1;
					bif.idx_lo = dp_wr_sel[2:0];
				end
				SEL_DATA_REG_0_LOW, SEL_DATA_REG_0_HIGH,
				SEL_DATA_REG_1_LOW, SEL_DATA_REG_1_HIGH: begin
					bif.we_lo  = 1'b1;
					bif.idx_lo = {2'h0, dp_wr_sel[1]};
					bif.be_lo  = dp_wr_sel[0] ? 2'h2 : 2'h1;
					bif.wd_lo  = {dp_wr_data[7:0], dp_wr_data[7:0]};
				end
				SEL_DATA_PAIR_LOW, SEL_DATA_PAIR_HIGH: begin
					bif.we_lo  = 1'b1;
					bif.we_hi  = 1'b1;
					bif.idx_lo = {2'h0, dp_wr_sel[0]};
					bif.idx_hi = {2'h1, dp_wr_sel[0]};
				end
				SEL_ADDR_PAIR: begin
					bif.we_lo  = 1'b1;
					bif.we_hi  = 1'b1;
					bif.idx_lo = BK_ADDR0;
					bif.idx_hi = BK_ADDR1;
				end
				default: begin
					bif.we_lo = 1'b0;
				end
			endcase
		end else if (apb_wr && apb_bank_hit) begin
			bif.we_lo  = 1'b1;
			bif.idx_lo = paddr[4:2];
			bif.wd_lo  = pwdata[15:0];
			bif.wbank  = paddr[5];
		end
	end

	// ------------------------------------------------------------------
	// Unbanked registers
	// ------------------------------------------------------------------
	// Program counter and vector table base
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_r  <= WIDE_RST;
			vtb_r <= WIDE_RST;
		end else begin
			if (sel_is(dp_wr_sel, SEL_PROGRAM_COUNTER, dp_wr_en)) begin
				pc_r <= dp_wr_data[19:0];
			end else if (apb_wr && paddr == OFS_PC) begin
				pc_r <= pwdata[19:0];
			end
			if (sel_is(dp_wr_sel, SEL_VECTOR_TABLE, dp_wr_en)) begin
				vtb_r <= dp_wr_data[19:0];
			end else if (apb_wr && paddr == OFS_VTB) begin
				vtb_r <= pwdata[19:0];
			end
		end
	end

	// Stack pointers and static base
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ustk_r  <= REG_RST;
			istk_r  <= REG_RST;
			statb_r <= REG_RST;
		end else begin
			if (sel_is(dp_wr_sel, SEL_USER_STACK, dp_wr_en)
				|| (sel_is(dp_wr_sel, SEL_ACTIVE_STACK, dp_wr_en) && u_eff_r)) begin
				ustk_r <= dp_wr_data[15:0];
			end else if (apb_wr && paddr == OFS_USTK) begin
				ustk_r <= pwdata[15:0];
			end
			if (sel_is(dp_wr_sel, SEL_INTR_STACK, dp_wr_en)
				|| (sel_is(dp_wr_sel, SEL_ACTIVE_STACK, dp_wr_en) && !u_eff_r)) begin
				istk_r <= dp_wr_data[15:0];
			end else if (apb_wr && paddr == OFS_ISTK) begin
				istk_r <= pwdata[15:0];
			end
			if (sel_is(dp_wr_sel, SEL_STATIC_BASE, dp_wr_en)) begin
				statb_r <= dp_wr_data[15:0];
			end else if (apb_wr && paddr == OFS_STATB) begin
				statb_r <= pwdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Flag word
	// ------------------------------------------------------------------
	// Explicit write, then arithmetic results, then interrupt entry
	always_comb begin
		flg_nxt = flg_r;
		if (sel_is(dp_wr_sel, SEL_FLAG_WORD, dp_wr_en)) begin
			flg_nxt = flg_clean(dp_wr_data);
		end else if (apb_wr && paddr == OFS_FLG) begin
			flg_nxt = flg_clean(pwdata);
		end
		if (alu_we[0]) flg_nxt[FL_C] = alu_val[0];
		if (alu_we[1]) flg_nxt[FL_Z] = alu_val[1];
		if (alu_we[2]) flg_nxt[FL_S] = alu_val[2];
		if (alu_we[3]) flg_nxt[FL_O] = alu_val[3];
		if (int_ack) begin
			flg_nxt[FL_I] = 1'b0;
			flg_nxt[FL_U] = 1'b0;
		end
		if (int_ack_single_step) flg_nxt[FL_D] = 1'b0;
		if (swi_exec && swi_vector <= SWI_U_MAX) flg_nxt[FL_U] = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flg_r <= FLG_RST;
		end else begin
			flg_r <= flg_nxt;
		end
	end

	// Bank and stack choice move only at instruction or entry boundaries
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_eff_r <= 1'b0;
			u_eff_r    <= 1'b0;
		end else if (instr_done || int_ack || swi_exec) begin
			bank_eff_r <= flg_nxt[FL_B];
			u_eff_r    <= flg_nxt[FL_U];
		end
	end

	// Single-step request after each completed instruction while flag D is set
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ss_req_r <= 1'b0;
		end else begin
			ss_req_r <= instr_done && flg_r[FL_D];
		end
	end

	// ------------------------------------------------------------------
	// Datapath read port, one cycle latency
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_r <= 32'h00000000;
		end else begin
			case (dp_rd_sel)
				SEL_DATA_REG_0, SEL_DATA_REG_1, SEL_DATA_REG_2, SEL_DATA_REG_3,
				SEL_ADDR_REG_0, SEL_ADDR_REG_1, SEL_FRAME_BASE:
					rd_r <= {16'h0000, bif.act[dp_rd_sel[2:0]]};
				SEL_DATA_REG_0_LOW:  rd_r <= {24'h000000, bif.act[BK_DATA0][7:0]};
				SEL_DATA_REG_0_HIGH: rd_r <= {24'h000000, bif.act[BK_DATA0][15:8]};
				SEL_DATA_REG_1_LOW:  rd_r <= {24'h000000, bif.act[BK_DATA1][7:0]};
				SEL_DATA_REG_1_HIGH: rd_r <= {24'h000000, bif.act[BK_DATA1][15:8]};
				SEL_DATA_PAIR_LOW:   rd_r <= {bif.act[BK_DATA2], bif.act[BK_DATA0]};
				SEL_DATA_PAIR_HIGH:  rd_r <= {bif.act[BK_DATA3], bif.act[BK_DATA1]};
				SEL_ADDR_PAIR:       rd_r <= {bif.act[BK_ADDR1], bif.act[BK_ADDR0]};
				SEL_PROGRAM_COUNTER: rd_r <= {12'h000, pc_r};
				SEL_VECTOR_TABLE:    rd_r <= {12'h000, vtb_r};
				SEL_USER_STACK:      rd_r <= {16'h0000, ustk_r};
				SEL_INTR_STACK:      rd_r <= {16'h0000, istk_r};
				SEL_ACTIVE_STACK:    rd_r <= {16'h0000, active_stack};
				SEL_STATIC_BASE:     rd_r <= {16'h0000, statb_r};
				SEL_FLAG_WORD:       rd_r <= {16'h0000, flg_r};
				default:             rd_r <= 32'h00000000;
			endcase
		end
	end

	// Output taps
	assign dp_rd_data          = rd_r;
	assign addr_reg_0          = bif.act[BK_ADDR0];
	assign addr_reg_1          = bif.act[BK_ADDR1];
	assign frame_base          = bif.act[BK_FRAME];
	assign static_base         = statb_r;
	assign active_stack        = u_eff_r ? ustk_r : istk_r;
	assign program_counter     = pc_r;
	assign vector_table_base   = vtb_r;
	assign processor_flag_word = flg_r;
	assign active_bank         = bank_eff_r;
	assign single_step_req     = ss_req_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		(flg_r & ~FLG_MASK) == 16'h0000) else $error("reserved flag bit set");
	a_ack_clears_ie: assert property (@(posedge clk) disable iff (rst)
		int_ack |=> !flg_r[FL_I] && !flg_r[FL_U]) else $error("entry left enable set");
	a_swi_clears_u: assert property (@(posedge clk) disable iff (rst)
		swi_exec && swi_vector <= SWI_U_MAX |=> !flg_r[FL_U] && !u_eff_r)
		else $error("low software interrupt kept user stack");
	a_step_request: assert property (@(posedge clk) disable iff (rst)
		instr_done && flg_r[FL_D] |=> single_step_req ##1 !single_step_req || instr_done)
		else $error("single-step request missing");
	a_step_clear: assert property (@(posedge clk) disable iff (rst)
		int_ack_single_step |=> !flg_r[FL_D]) else $error("step flag survived ack");
	a_carry_update: assert property (@(posedge clk) disable iff (rst)
		alu_we[0] |=> flg_r[FL_C] == $past(alu_val[0])) else $error("carry not captured");
	a_bank_deferred: assert property (@(posedge clk) disable iff (rst)
		!(instr_done || int_ack || swi_exec) |=> $stable(bank_eff_r) && $stable(u_eff_r))
		else $error("bank or stack changed mid-instruction");
	a_pair_read: assert property (@(posedge clk) disable iff (rst)
		dp_rd_sel == SEL_DATA_PAIR_HIGH
		|=> dp_rd_data == {$past(bif.act[BK_DATA3]), $past(bif.act[BK_DATA1])})
		else $error("high data pair misordered");
	a_mask_gate: assert property (@(posedge clk) disable iff (rst)
		int_accept && int_req_maskable |-> flg_r[FL_I]) else $error("masked interrupt accepted");
	a_prio_gate: assert property (@(posedge clk) disable iff (rst)
		int_accept |-> int_req_prio > flg_r[FL_IPL_HI:FL_IPL_LO])
		else $error("interrupt at or below level accepted");
endmodule : crsf_regs
